// >>> ufd_pkg.sv
/*
 Package for the serial FIFO control shadow and function disable register slice.
 Assumes an APB slave with 32-bit data, one aligned word per register.
*/
`default_nettype none
package ufd_pkg;
	// Register indices as printed; byte address is four times the index
	localparam logic [7:0]  UFD_IDX_SER1_SHADOW  = 8'h20;
	localparam logic [7:0]  UFD_IDX_SER2_SHADOW  = 8'h21;
	localparam logic [7:0]  UFD_IDX_DISABLE      = 8'h22;
	localparam logic [11:0] UFD_ADDR_SER1_SHADOW = 12'h080;
	localparam logic [11:0] UFD_ADDR_SER2_SHADOW = 12'h084;
	localparam logic [11:0] UFD_ADDR_DISABLE     = 12'h088;

	// Shadow field positions
	localparam int UFD_FCR_FIFO_EN  = 0;
	localparam int UFD_FCR_RX_CLR   = 1;
	localparam int UFD_FCR_TX_CLR   = 2;
	localparam int UFD_FCR_DMA_MODE = 3;
	localparam int UFD_FCR_TRIG_LO  = 6;
	localparam int UFD_FCR_TRIG_HI  = 7;

	// Disable register field positions
	localparam int UFD_DIS_WP      = 0;
	localparam int UFD_DIS_FLOPPY  = 3;
	localparam int UFD_DIS_MIDI    = 4;
	localparam int UFD_DIS_SER2    = 5;
	localparam int UFD_DIS_SER1    = 6;
	localparam int UFD_DIS_PAR     = 7;
	localparam logic [7:0] UFD_DIS_WMASK = 8'hF9;

	localparam logic [7:0] UFD_DIS_RESET    = 8'h00;
	localparam logic [7:0] UFD_SHADOW_RESET = 8'h00;
	localparam logic [1:0] UFD_LOCK_ALTFN   = 2'h1;

	// Pin synchroniser: depth, lanes, lane positions and the levels held in reset
	localparam int         UFD_SYNC_STAGES  = 2;
	localparam int         UFD_SYNC_PINS    = 4;
	localparam int         UFD_PIN_DS0      = 3;
	localparam int         UFD_PIN_DS1      = 2;
	localparam int         UFD_PIN_WP       = 1;
	localparam int         UFD_PIN_LOCK     = 0;
	// Floppy pins idle high; the lock pin reads as unlocked until it is sampled
	localparam logic [3:0] UFD_SYNC_RESET   = 4'hE;

	typedef struct packed {
		logic floppy;
		logic midi;
		logic ser_one;
		logic ser_two;
		logic parallel;
	} ufd_func_type;

	typedef struct packed {
		logic       valid;
		logic [7:0] data;
	} ufd_fcr_wr_type;
endpackage
`default_nettype wire

// >>> ufd_regs.sv
/*
 Serial FIFO control shadows and function disable override, APB slave.
 Assumes the serial cores pulse a strobe with the FIFO control byte on each write,
 the lock pin and floppy pins are asynchronous, and presetn is the standby power-on reset.
*/
// The APB register port was decided locally.
`timescale 1ns/1ns
`default_nettype none
// Operation
// RL1: Word 20 reads back the FIFO control value last written to serial port one.
// RL2: Word 21 reads back the FIFO control value last written to serial port two.
// RL3: Shadows keep enable, rx clear, tx clear, DMA mode, bits 5:4 and trigger in bits 7:6.
// RL4: Disable bits 7:3 at zero leave each function to its activate bit, at one disable it.
// RL5: Bit 3 disables the floppy controller.
// RL6: Bit 4 disables the MIDI serial interface.
// RL7: Bit 5 disables serial port two.
// RL8: Bit 6 disables serial port one.
// RL9: Bit 7 disables the parallel port.
// RL10: Bit 0 forces floppy write protect over the pin and the forced protect bit.
// RL11: Write protect to the core is ds0 and force, or ds1 and force, or pin, or bit 0.
// RL12: The force term is bit 0 of logical device 0 register F1, given as an input.
// RL13: Bits 2:1 of the disable register read as zero.
// RL14: The disable register is read-only when the lock field is 01 and the pin is 1.
module ufd_regs
	import ufd_pkg::*;
#(
	// Flip-flops between each pin and the logic that reads it
	parameter int SYNC_STAGES = UFD_SYNC_STAGES
)
(
	// APB
	input  wire logic        pclk,
	input  wire logic        presetn,
	input  wire logic        psel,
	input  wire logic        penable,
	input  wire logic        pwrite,
	input  wire logic [11:0] paddr,
	input  wire logic [31:0] pwdata,
	input  wire logic [3:0]  pstrb,
	output logic [31:0]      prdata,
	output logic             pready,
	output logic             pslverr,
	// Serial FIFO control writes
	input  wire logic        ser1_fcr_wr,
	input  wire logic [7:0]  ser1_fcr_data,
	input  wire logic        ser2_fcr_wr,
	input  wire logic [7:0]  ser2_fcr_data,
	// Activate bits from the configuration registers
	input  wire ufd_func_type activate,
	output ufd_func_type     active_q,
	// Floppy write protect
	input  wire logic        force_write_protect,
	input  wire logic        drive_select_zero_n,
	input  wire logic        drive_select_one_n,
	input  wire logic        write_protect_n,
	output logic             core_write_protect_n_q,
	// Lock pin and its alternate-function field
	input  wire logic        disable_lock_gpio,
	input  wire logic [1:0]  lock_altfn_sel,
	output logic             disable_locked_q
);
	// Shadow values and the disable register
	logic [7:0]               ser1_q;
	logic [7:0]               ser2_q;
	logic [7:0]               dis_q;
	logic [7:0]               dis_d;
	ufd_fcr_wr_type           wr1;
	ufd_fcr_wr_type           wr2;

	// Raw and synchronised pin lanes
	logic [UFD_SYNC_PINS-1:0] pin_raw;
	logic [UFD_SYNC_PINS-1:0] pin_s;
	logic                     pin_ds0_n;
	logic                     pin_ds1_n;
	logic                     pin_wp_n;
	logic                     pin_lock;

	// Bus decode
	logic                     setup;
	logic                     access;
	logic                     hit_ser1;
	logic                     hit_ser2;
	logic                     hit_dis;
	logic                     mapped;
	logic                     bad;
	logic                     locked;
	logic                     dis_we;
	logic [7:0]               rd_byte;
	logic [31:0]              rd_word;

	// Next values of the registered outputs
	logic                     pready_d;
	logic                     pslverr_d;
	logic [31:0]              prdata_d;
	ufd_func_type             active_d;
	logic                     wp_d;

	// Fewer than two stages would let a metastable level reach the decode
	if (SYNC_STAGES < 2) begin : g_depth_check
		$error("Synchroniser depth must be at least two");
	end

	// Word decode shared by the read mux, the error check and the write enable
	function automatic logic addr_is(input logic [11:0] addr, input logic [11:0] word);
		return addr == word;
	endfunction

	// Override bits gathered in the order of the function struct
	function automatic ufd_func_type disable_map(input logic [7:0] dis);
		ufd_func_type m;
		m.floppy   = dis[UFD_DIS_FLOPPY]; // RL5
		m.midi     = dis[UFD_DIS_MIDI];   // RL6
		m.ser_one  = dis[UFD_DIS_SER1];   // RL8
		m.ser_two  = dis[UFD_DIS_SER2];   // RL7
		m.parallel = dis[UFD_DIS_PAR];    // RL9
		return m;
	endfunction

	// Strobes come from logic on pclk, so no synchroniser
	assign wr1 = {ser1_fcr_wr, ser1_fcr_data};
	assign wr2 = {ser2_fcr_wr, ser2_fcr_data};

	ufd_shadow u_ser1 (
		.pclk    (pclk),
		.presetn (presetn),
		.wr      (wr1),
		.value_q (ser1_q) // RL1 RL3
	);

	ufd_shadow u_ser2 (
		.pclk    (pclk),
		.presetn (presetn),
		.wr      (wr2),
		.value_q (ser2_q) // RL2 RL3
	);

	// Pin lanes: ds0, ds1, write protect, lock pin
	assign pin_raw = {drive_select_zero_n, drive_select_one_n,
		write_protect_n, disable_lock_gpio};

	// Each stage reads only the stage before it
	genvar st;
	generate
		for (st = 0; st < SYNC_STAGES; st = st + 1) begin : g_sync
			logic [UFD_SYNC_PINS-1:0] q;
			wire  [UFD_SYNC_PINS-1:0] d;

			if (st == 0) begin : g_src
				assign d = pin_raw;
			end else begin : g_src
				assign d = g_sync[st-1].q;
			end

			always_ff @(posedge pclk or negedge presetn) begin
				if (!presetn)
					q <= UFD_SYNC_RESET;
				else
					q <= d;
			end
		end
	endgenerate

	assign pin_s     = g_sync[SYNC_STAGES-1].q;
	assign pin_ds0_n = pin_s[UFD_PIN_DS0];
	assign pin_ds1_n = pin_s[UFD_PIN_DS1];
	assign pin_wp_n  = pin_s[UFD_PIN_WP];
	assign pin_lock  = pin_s[UFD_PIN_LOCK];

	// Lock acts on the synchronised pin at once; the status output lags one edge
	assign locked = (lock_altfn_sel == UFD_LOCK_ALTFN) && pin_lock; // RL14

	// Bus phases
	assign setup  = psel && !penable;
	assign access = psel && penable;

	// Address decode
	assign hit_ser1 = addr_is(paddr, UFD_ADDR_SER1_SHADOW); // RL1
	assign hit_ser2 = addr_is(paddr, UFD_ADDR_SER2_SHADOW); // RL2
	assign hit_dis  = addr_is(paddr, UFD_ADDR_DISABLE);
	assign mapped   = hit_ser1 || hit_ser2 || hit_dis;

	// Shadows are read-only; writing them or an unmapped word is an error
	assign bad = !mapped || (pwrite && !hit_dis);

	// A locked write is dropped without an error so the host sees no fault
	assign dis_we = access && pwrite && hit_dis && pstrb[0] && !locked; // RL14

	// Reserved bits never reach the register, so they read back as zero
	assign dis_d = dis_we ? (pwdata[7:0] & UFD_DIS_WMASK) : dis_q; // RL13

	// Read mux
	assign rd_byte = hit_ser1 ? ser1_q :
		(hit_ser2 ? ser2_q :
		(hit_dis ? dis_q : 8'h00)); // RL1 RL2
	assign rd_word = {24'h00_0000, rd_byte};

	// Answer is prepared in the setup cycle, so the access cycle needs no wait
	assign pready_d  = setup;
	assign pslverr_d = setup && bad;
	assign prdata_d  = (setup && !pwrite) ? rd_word : 32'h0000_0000;

	// A set override wins over the activate bit
	assign active_d = activate & ~disable_map(dis_q); // RL4

	// Equation kept with the levels as named, active-low pin levels used directly
	assign wp_d = (pin_ds0_n && force_write_protect) // RL11 RL12
		|| (pin_ds1_n && force_write_protect)
		|| pin_wp_n
		|| dis_q[UFD_DIS_WP]; // RL10

	// Disable register
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn)
			dis_q <= UFD_DIS_RESET; // RL14
		else
			dis_q <= dis_d;
	end

	// Ready pulse
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn)
			pready <= 1'b0;
		else
			pready <= pready_d;
	end

	// Error response
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn)
			pslverr <= 1'b0;
		else
			pslverr <= pslverr_d;
	end

	// Read data, zero outside read answers
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn)
			prdata <= 32'h0000_0000;
		else
			prdata <= prdata_d;
	end

	// Gated function enables
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn)
			active_q <= '0;
		else
			active_q <= active_d;
	end

	// Write protect to the floppy core
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn)
			core_write_protect_n_q <= 1'b0;
		else
			core_write_protect_n_q <= wp_d;
	end

	// Lock status
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn)
			disable_locked_q <= 1'b0;
		else
			disable_locked_q <= locked;
	end
endmodule
`default_nettype wire

// >>> ufd_regs_assertions.sv
/*
 Checker for the shadow and function disable register slice.
 Assumes it is bound to every ufd_regs instance and sees only its ports.
*/
`timescale 1ns/1ns
`default_nettype none
module ufd_regs_assertions
	import ufd_pkg::*;
(
	// Clock and reset
	input wire logic         pclk,
	input wire logic         presetn,
	// APB
	input wire logic         psel,
	input wire logic         penable,
	input wire logic         pwrite,
	input wire logic [11:0]  paddr,
	input wire logic [31:0]  prdata,
	input wire logic         pready,
	input wire logic         pslverr,
	// Serial strobe, function and lock
	input wire logic         ser1_fcr_wr,
	input wire logic [7:0]   ser1_fcr_data,
	input wire ufd_func_type activate,
	input wire ufd_func_type active_q,
	input wire logic [1:0]   lock_altfn_sel,
	input wire logic         disable_locked_q
);
	default clocking @(posedge pclk); endclocking
	default disable iff (!presetn);
	sequence s_setup;
		psel && !penable;
	endsequence
	// Strobe lands one edge before the read setup, so the answer must carry it
	sequence s_strobe_rd;
		ser1_fcr_wr ##1 s_setup ##0 (!pwrite && paddr == UFD_ADDR_SER1_SHADOW);
	endsequence
	a_ready_follows_setup: assert property (s_setup |=> pready) else $error("no ready");
	a_ready_one_cycle: assert property (pready |=> !pready) else $error("ready held");
	a_upper_zero: assert property (pready |-> prdata[31:8] == 24'h0) else $error("upper set");
	a_rsvd_read_zero: assert property (pready && paddr == UFD_ADDR_DISABLE |->
		prdata[2:1] == 2'h0) else $error("reserved bits set");
	a_shadow_wr_err: assert property (pready && pwrite && paddr == UFD_ADDR_SER1_SHADOW
		|-> pslverr) else $error("shadow write accepted");
	a_shadow_read: assert property (s_strobe_rd |=>
		prdata[7:0] == $past(ser1_fcr_data, 2)) else $error("shadow value wrong");
	a_active_gated: assert property ((active_q & ~$past(activate)) == 5'h00)
		else $error("active without activate");
	a_lock_field: assert property (disable_locked_q |->
		$past(lock_altfn_sel) == UFD_LOCK_ALTFN) else $error("lock with wrong field");
endmodule
bind ufd_regs ufd_regs_assertions u_chk (
	.pclk             (pclk),
	.presetn          (presetn),
	.psel             (psel),
	.penable          (penable),
	.pwrite           (pwrite),
	.paddr            (paddr),
	.prdata           (prdata),
	.pready           (pready),
	.pslverr          (pslverr),
	.ser1_fcr_wr      (ser1_fcr_wr),
	.ser1_fcr_data    (ser1_fcr_data),
	.activate         (activate),
	.active_q         (active_q),
	.lock_altfn_sel   (lock_altfn_sel),
	.disable_locked_q (disable_locked_q)
);
`default_nettype wire

// >>> ufd_regs_tb_top.sv
/*
 Bench for the shadow and function disable register slice.
 Assumes the design answers every APB access by itself.
*/
`timescale 1ns/1ns
`default_nettype none
module ufd_regs_tb_top
	import ufd_pkg::*;
;
	typedef struct packed {logic [7:0] v, rd; logic [4:0] act; logic wp;} ufd_row_type;
	logic         pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0, s1w = 0, s2w = 0;
	logic         frc = 0, ds0n = 0, ds1n = 0, wpn = 0, gpio = 0, pready, pslverr, wp_q, lk_q, e;
	logic [1:0]   alt = 0;
	logic [3:0]   strb = 4'hF;
	logic [7:0]   s1d = 0, s2d = 0;
	logic [11:0]  paddr = 0;
	logic [31:0]  pwdata = 0, prdata, r;
	ufd_func_type act = 5'h1F, act_q;
	int           num_errors = 0, n_tests = 0;
	ufd_row_type  rows[8] = '{{8'hFF, 8'hF9, 5'h00, 1'b1}, {8'h08, 8'h08, 5'h0F, 1'b0},
		{8'h10, 8'h10, 5'h17, 1'b0}, {8'h20, 8'h20, 5'h1D, 1'b0},
		{8'h40, 8'h40, 5'h1B, 1'b0}, {8'h80, 8'h80, 5'h1E, 1'b0},
		{8'h07, 8'h01, 5'h1F, 1'b1}, {8'h00, 8'h00, 5'h1F, 1'b0}};
	ufd_regs dut (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .pstrb(strb),
		.prdata, .pready, .pslverr, .ser1_fcr_wr(s1w), .ser1_fcr_data(s1d),
		.ser2_fcr_wr(s2w), .ser2_fcr_data(s2d), .activate(act), .active_q(act_q),
		.force_write_protect(frc), .drive_select_zero_n(ds0n), .drive_select_one_n(ds1n),
		.write_protect_n(wpn), .core_write_protect_n_q(wp_q), .disable_lock_gpio(gpio),
		.lock_altfn_sel(alt), .disable_locked_q(lk_q));
	always #5 pclk = ~pclk;
	task automatic finish_test;
		if (num_errors == 0 && n_tests > 0) $display("Finished cleanly");
		else $display("Finished with errors");
		$finish;
	endtask
	task automatic chk(input string n, input logic [31:0] s, x);
		n_tests++;
		if (s !== x) begin
			num_errors++;
			$display("FAIL %s expected %h seen %h", n, x, s);
		end
	endtask
	// Also ends any strobe raised just before, so a read can follow it at once
	task automatic apb(input logic w, input logic [11:0] a, input logic [7:0] d);
		int i;
		@(posedge pclk);
		{s1w, s2w} <= 2'b00;
		{psel, penable, pwrite, paddr, pwdata} <= {2'b10, w, a, 24'h0, d};
		@(posedge pclk);
		penable <= 1'b1;
		i = 0;
		@(posedge pclk);
		while (pready !== 1'b1 && i < 20) begin
			@(posedge pclk);
			i++;
		end
		if (pready !== 1'b1) begin
			num_errors++;
			finish_test;
		end
		{r, e} = {prdata, pslverr};
		{psel, penable} <= 2'b00;
	endtask
	initial begin
		repeat (16) @(posedge pclk);
		presetn <= 1'b1;
		apb(0, UFD_ADDR_DISABLE, 0);
		chk("reset", r, 0);
		{s1w, s1d} <= 9'h1C9;
		apb(0, UFD_ADDR_SER1_SHADOW, 0);
		chk("shadow1", r, 32'hC9);
		{s2w, s2d} <= 9'h136;
		apb(0, UFD_ADDR_SER2_SHADOW, 0);
		chk("shadow2", r, 32'h36);
		apb(1, UFD_ADDR_SER1_SHADOW, 8'h00);
		chk("shadow_wr_err", e, 1);
		apb(0, UFD_ADDR_SER1_SHADOW, 0);
		chk("shadow_ro", r, 32'hC9);
		chk("shadow_rd_err", e, 0);
		apb(0, 12'h08C, 0);
		chk("unmapped", e, 1);
		chk("unmapped_data", r, 0);
		foreach (rows[i]) begin
			apb(1, UFD_ADDR_DISABLE, rows[i].v);
			apb(0, UFD_ADDR_DISABLE, 0);
			chk("disable", r, rows[i].rd);
			chk("active", act_q, rows[i].act);
			chk("wp_force", wp_q, rows[i].wp);
		end
		act <= 5'h0A;
		repeat (2) @(posedge pclk);
		chk("activate", act_q, 5'h0A);
		for (int k = 0; k < 16; k++) begin
			{frc, ds0n, ds1n, wpn} <= k[3:0];
			repeat (4) @(posedge pclk);
			chk("wp_eq", wp_q, (k[3] & k[2]) | (k[3] & k[1]) | k[0]);
		end
		{alt, gpio} <= {UFD_LOCK_ALTFN, 1'b1};
		repeat (4) @(posedge pclk);
		chk("locked", lk_q, 1);
		apb(1, UFD_ADDR_DISABLE, 8'hFF);
		apb(0, UFD_ADDR_DISABLE, 0);
		chk("lock_ro", r, 0);
		alt <= 2'h2;
		repeat (4) @(posedge pclk);
		chk("unlocked", lk_q, 0);
		apb(1, UFD_ADDR_DISABLE, 8'h80);
		apb(0, UFD_ADDR_DISABLE, 0);
		chk("lock_rw", r, 32'h80);
		{alt, gpio} <= {UFD_LOCK_ALTFN, 1'b0};
		repeat (4) @(posedge pclk);
		chk("pin_low", lk_q, 0);
		apb(1, UFD_ADDR_DISABLE, 8'h40);
		apb(0, UFD_ADDR_DISABLE, 0);
		chk("pin_low_rw", r, 32'h40);
		strb <= 4'h0;
		apb(1, UFD_ADDR_DISABLE, 8'h01);
		strb <= 4'hF;
		apb(0, UFD_ADDR_DISABLE, 0);
		chk("no_strobe", r, 32'h40);
		presetn <= 1'b0;
		@(posedge pclk);
		presetn <= 1'b1;
		apb(0, UFD_ADDR_DISABLE, 0);
		chk("rereset", r, 0);
		apb(0, UFD_ADDR_SER1_SHADOW, 0);
		chk("rereset_shadow", r, 0);
		finish_test;
	end
endmodule
`default_nettype wire

// >>> ufd_shadow.sv
/*
 Byte shadow register: holds the last FIFO control value written to one serial port.
 Assumes the write strobe is on pclk and lasts one cycle per write.
*/
`timescale 1ns/1ns
`default_nettype none
module ufd_shadow
	import ufd_pkg::*;
(
	// Clock and reset
	input  wire logic           pclk,
	input  wire logic           presetn,
	// Captured write
	input  wire ufd_fcr_wr_type wr,
	output logic [7:0]          value_q
);
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn)
			value_q <= UFD_SHADOW_RESET;
		else if (wr.valid)
			value_q <= wr.data;
	end
endmodule
`default_nettype wire
